//--- verilog/fcg_pkg.sv
// Shared constants, entry layouts and helpers for the front-end configuration block
package fcg_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_CHAN = 16;
  localparam int NUM_SETUP = 8;
  localparam int NUM_AIN = 8;
  localparam int NUM_GPO = 3;
  localparam int AXI_AW = 8;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_BIAS = 6'h01;
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam logic [5:0] IDX_IO = 6'h03;
  localparam logic [5:0] IDX_REF = 6'h04;
  localparam logic [5:0] IDX_CHAN_BASE = 6'h10;
  localparam logic [5:0] IDX_SETUP_BASE = 6'h20;

  // ==========================================================================
  // Control word fields
  // ==========================================================================
  localparam int CTRL_W = 6;
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_SEQ_RUN = 1;
  localparam int CTRL_SOFT_RST = 2;
  localparam int CTRL_STB_EXC = 3;
  localparam int CTRL_STB_IND = 4;
  localparam int CTRL_CLK_USED = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h02;

  // ==========================================================================
  // io_pin_control fields
  // ==========================================================================
  localparam logic [15:0] IO_RESET = 16'h0000;
  localparam logic [15:0] IO_WR_MASK = 16'h07ee;
  localparam int IO_CTRL_LSB = 1;
  localparam int IO_DATA_LSB = 5;
  localparam int IO_INTSEL_LSB = 8;
  localparam int IO_SYNCCLR_BIT = 10;
  localparam logic [1:0] INT_SEL_CLK_PIN = 2'h1;

  localparam logic [NUM_AIN-1:0] BIAS_RESET = 8'h00;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  localparam logic [2:0] EXC_OFF = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Entry layouts
  // ==========================================================================
  typedef struct packed {
    logic [4:0] route_b;
    logic [4:0] route_a;
    logic bridge;
    logic [2:0] setup;
    logic [4:0] neg;
    logic [4:0] pos;
    logic en;
  } fcg_chan_type;

  typedef struct packed {
    logic [2:0] mag_b;
    logic [2:0] mag_a;
    logic skip;
    logic [2:0] gain;
  } fcg_setup_type;

  localparam fcg_chan_type CHAN0_RESET = 25'h0000041;
  localparam fcg_chan_type CHAN_RESET = 25'h0000000;
  localparam fcg_setup_type SETUP_RESET = 10'h000;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] fcg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : fcg_merge

  function automatic logic fcg_mapped(input logic [5:0] idx);
    return (idx <= IDX_REF) ||
           (idx >= IDX_CHAN_BASE && idx < IDX_CHAN_BASE + 6'(NUM_CHAN)) ||
           (idx >= IDX_SETUP_BASE && idx < IDX_SETUP_BASE + 6'(NUM_SETUP));
  endfunction : fcg_mapped

endpackage : fcg_pkg

//--- verilog/fcg_seq.sv
// Channel sequencer stepping through enabled entries at conversion boundaries
`timescale 1ns/10ps
module fcg_seq
  import fcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic conv_done,
  input wire logic [NUM_CHAN-1:0] en_mask,
  output logic [3:0] cur_ch_ff,
  output logic step_ff
);

  // ==========================================================================
  // Next enabled entry after the current one, wrapping round
  // ==========================================================================
  function automatic logic [3:0] next_chan(input logic [NUM_CHAN-1:0] m, input logic [3:0] c);
    logic [3:0] r;
    logic [3:0] k;
    r = c;
    for (int i = NUM_CHAN - 1; i >= 1; i--) begin
      k = c + 4'(i);
      if (m[k]) begin
        r = k;
      end
    end
    return r;
  endfunction : next_chan

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ch_ff <= 4'h0;
    end else if (run && conv_done) begin // R4 R17
      cur_ch_ff <= next_chan(en_mask, cur_ch_ff);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      step_ff <= 1'b0;
    end else begin
      step_ff <= run && conv_done; // R4
    end
  end

endmodule : fcg_seq

//--- verilog/fcg_top.sv
// Front-end configuration registers, input routing and general-purpose outputs
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
// Behaviour
// R1: any pin may be positive or negative input
// R2: entry has 5-bit positive and negative selects
// R3: differential or single-ended purely by programming
// R4: input selection changes only at conversion boundaries; the code reloads it every cycle while stopped or in standby
// R5: two excitation sources, per-setup magnitudes
// R6: excitation pins routed from first channel entry
// R7: standby with control bit turns excitation off
// R8: bias generator pins chosen by bias control
// R9: two inputs can become second reference
// R10: each output enabled by its control bit
// R11: enabled output follows its level bit
// R12: third output can flag standby
// R13: each entry carries bridge switch bit
// R14: gain field selects 1 to 128
// R15: skip bit forces unity gain
// R16: sixteen entries, eight setups, entry picks setup
// R17: sequencer converts enabled entries in turn
// R18: indicator enable drives standby onto third output
// R19: interrupt selection on clock pin overrides clock
// R20: reserved io bits ignore writes, read zero
module fcg_top
  import fcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done,
  input wire logic irq_event,
  output logic [4:0] positive_input_select,
  output logic [4:0] negative_input_select,
  output logic [2:0] gain_stage_select,
  output logic gain_stage_skip,
  output logic [2:0] excitation_a_magnitude,
  output logic [2:0] excitation_b_magnitude,
  output logic [4:0] excitation_a_pin_route,
  output logic [4:0] excitation_b_pin_route,
  output logic [NUM_AIN-1:0] bias_pin_enable,
  output logic bridge_low_side_switch,
  output logic second_ref_enable,
  output logic standby_active,
  output logic [3:0] active_channel,
  output logic [NUM_GPO-1:0] gp_pin_out,
  output logic [NUM_GPO-1:0] gp_pin_oe_n,
  output logic clk_pin_clock_out_en,
  output logic clk_pin_irq_sel,
  output logic clk_pin_irq_out,
  output logic sync_clear_bit
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [CTRL_W-1:0] ctrl_ff;
  logic [NUM_AIN-1:0] bias_ff;
  logic [15:0] io_ff;
  logic ref2_ff;
  fcg_chan_type chan_ff [NUM_CHAN];
  fcg_setup_type setup_ff [NUM_SETUP];

  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [5:0] aw_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  logic wr_go;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic soft_clr;
  logic [NUM_CHAN-1:0] en_mask;
  logic [3:0] cur_ch;
  logic seq_step;
  logic load;
  fcg_chan_type cur_entry;
  fcg_setup_type cur_setup;

  // ==========================================================================
  // AXI4-Lite write side
  // ==========================================================================
  // Address and data are captured independently; the write fires once both are held
  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      aw_idx_ff <= 6'h00;
    end else if (awready_ff && s_axi_awvalid) begin
      awready_ff <= 1'b0;
      aw_idx_ff <= s_axi_awaddr[7:2];
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wready_ff <= 1'b1;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (wready_ff && s_axi_wvalid) begin
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= fcg_mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Old value of the addressed word, so partial strobes keep untouched bytes
  always_comb begin
    wr_old = 32'h00000000;
    if (aw_idx_ff == IDX_CTRL) begin
      wr_old[CTRL_W-1:0] = ctrl_ff;
    end else if (aw_idx_ff == IDX_BIAS) begin
      wr_old[NUM_AIN-1:0] = bias_ff;
    end else if (aw_idx_ff == IDX_IO) begin
      wr_old[15:0] = io_ff;
    end else if (aw_idx_ff == IDX_REF) begin
      wr_old[0] = ref2_ff;
    end else if (aw_idx_ff >= IDX_CHAN_BASE && aw_idx_ff < IDX_CHAN_BASE + 6'(NUM_CHAN)) begin
      wr_old[24:0] = chan_ff[aw_idx_ff[3:0]];
    end else if (aw_idx_ff >= IDX_SETUP_BASE && aw_idx_ff < IDX_SETUP_BASE + 6'(NUM_SETUP)) begin
      wr_old[9:0] = setup_ff[aw_idx_ff[2:0]];
    end
  end

  assign wr_val = fcg_merge(wr_old, wdata_ff, wstrb_ff);
  // Soft reset returns every setting to its power-on value
  assign soft_clr = wr_go && (aw_idx_ff == IDX_CTRL) && wr_val[CTRL_SOFT_RST];

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (soft_clr) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_go && aw_idx_ff == IDX_CTRL) begin
      ctrl_ff <= wr_val[CTRL_W-1:0];
      ctrl_ff[CTRL_SOFT_RST] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bias_ff <= BIAS_RESET;
    end else if (soft_clr) begin
      bias_ff <= BIAS_RESET;
    end else if (wr_go && aw_idx_ff == IDX_BIAS) begin
      bias_ff <= wr_val[NUM_AIN-1:0]; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_ff <= IO_RESET;
    end else if (soft_clr) begin
      io_ff <= IO_RESET;
    end else if (wr_go && aw_idx_ff == IDX_IO) begin
      io_ff <= wr_val[15:0] & IO_WR_MASK; // R20
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref2_ff <= 1'b0;
    end else if (soft_clr) begin
      ref2_ff <= 1'b0;
    end else if (wr_go && aw_idx_ff == IDX_REF) begin
      ref2_ff <= wr_val[0]; // R9
    end
  end

  // Entries hold any 5-bit code in either select, so pairs are free-form
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_ff[i] <= (i == 0) ? CHAN0_RESET : CHAN_RESET;
      end
    end else if (soft_clr) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_ff[i] <= (i == 0) ? CHAN0_RESET : CHAN_RESET;
      end
    end else if (wr_go && aw_idx_ff[5:4] == IDX_CHAN_BASE[5:4]) begin
      chan_ff[aw_idx_ff[3:0]] <= fcg_chan_type'(wr_val[24:0]); // R1 R2 R3 R13 R16
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SETUP; i++) begin
        setup_ff[i] <= SETUP_RESET;
      end
    end else if (soft_clr) begin
      for (int i = 0; i < NUM_SETUP; i++) begin
        setup_ff[i] <= SETUP_RESET;
      end
    end else if (wr_go && aw_idx_ff[5:3] == IDX_SETUP_BASE[5:3]) begin
      setup_ff[aw_idx_ff[2:0]] <= fcg_setup_type'(wr_val[9:0]); // R5 R14 R16
    end
  end

  // ==========================================================================
  // AXI4-Lite read side
  // ==========================================================================
  function automatic logic [31:0] read_word(input logic [5:0] idx);
    logic [31:0] r;
    r = 32'h00000000;
    if (idx == IDX_CTRL) begin
      r[CTRL_W-1:0] = ctrl_ff;
    end else if (idx == IDX_BIAS) begin
      r[NUM_AIN-1:0] = bias_ff;
    end else if (idx == IDX_STATUS) begin
      r[3:0] = active_channel;
      r[6:4] = cur_entry.setup;
      r[7] = standby_active;
      r[8] = bridge_low_side_switch;
      r[9] = ctrl_ff[CTRL_SEQ_RUN];
    end else if (idx == IDX_IO) begin
      r[15:0] = io_ff & IO_WR_MASK; // R20
    end else if (idx == IDX_REF) begin
      r[0] = ref2_ff;
    end else if (idx >= IDX_CHAN_BASE && idx < IDX_CHAN_BASE + 6'(NUM_CHAN)) begin
      r[24:0] = chan_ff[idx[3:0]];
    end else if (idx >= IDX_SETUP_BASE && idx < IDX_SETUP_BASE + 6'(NUM_SETUP)) begin
      r[9:0] = setup_ff[idx[2:0]];
    end
    return r;
  endfunction : read_word

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arready_ff && s_axi_arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= read_word(s_axi_araddr[7:2]);
      rresp_ff <= fcg_mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    en_mask = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      en_mask[i] = chan_ff[i].en;
    end
  end

  fcg_seq u_seq (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(ctrl_ff[CTRL_SEQ_RUN] && !ctrl_ff[CTRL_STANDBY]),
    .conv_done(conv_done),
    .en_mask(en_mask),
    .cur_ch_ff(cur_ch),
    .step_ff(seq_step)
  );

  assign cur_entry = chan_ff[cur_ch];
  assign cur_setup = setup_ff[cur_entry.setup]; // R16
  // While stopped nothing converts, so settings may follow software at once
  assign load = seq_step || !ctrl_ff[CTRL_SEQ_RUN] || ctrl_ff[CTRL_STANDBY];

  // ==========================================================================
  // Front-end drive, latched per conversion while running and every cycle otherwise; bias, second reference and standby follow every cycle
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      positive_input_select <= CHAN0_RESET.pos;
      negative_input_select <= CHAN0_RESET.neg;
      active_channel <= 4'h0;
      bridge_low_side_switch <= 1'b0;
    end else if (load) begin // R4
      positive_input_select <= cur_entry.pos; // R1 R3
      negative_input_select <= cur_entry.neg; // R1 R3
      active_channel <= cur_ch; // R17
      bridge_low_side_switch <= cur_entry.bridge; // R13
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gain_stage_select <= GAIN_UNITY;
      gain_stage_skip <= 1'b0;
    end else if (load) begin
      gain_stage_skip <= cur_setup.skip; // R15
      gain_stage_select <= cur_setup.skip ? GAIN_UNITY : cur_setup.gain; // R14 R15
    end
  end

  // Standby gating acts at once; magnitude changes wait for a boundary while the sequencer runs, and load every cycle otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      excitation_a_magnitude <= EXC_OFF;
      excitation_b_magnitude <= EXC_OFF;
    end else if (ctrl_ff[CTRL_STANDBY] && ctrl_ff[CTRL_STB_EXC]) begin
      excitation_a_magnitude <= EXC_OFF; // R7
      excitation_b_magnitude <= EXC_OFF; // R7
    end else if (load) begin
      excitation_a_magnitude <= cur_setup.mag_a; // R5
      excitation_b_magnitude <= cur_setup.mag_b; // R5
    end
  end

  // Routes always come from entry 0; equal routes are allowed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      excitation_a_pin_route <= CHAN0_RESET.route_a;
      excitation_b_pin_route <= CHAN0_RESET.route_b;
    end else if (load) begin
      excitation_a_pin_route <= chan_ff[0].route_a; // R6
      excitation_b_pin_route <= chan_ff[0].route_b; // R6
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bias_pin_enable <= BIAS_RESET;
      second_ref_enable <= 1'b0;
      standby_active <= 1'b0;
    end else begin
      bias_pin_enable <= bias_ff; // R8
      second_ref_enable <= ref2_ff; // R9
      standby_active <= ctrl_ff[CTRL_STANDBY];
    end
  end

  // ==========================================================================
  // General-purpose outputs
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gp_pin_out <= '0;
      gp_pin_oe_n <= '1;
    end else begin
      for (int p = 0; p < NUM_GPO; p++) begin
        gp_pin_oe_n[p] <= !io_ff[IO_CTRL_LSB + p]; // R10
        gp_pin_out[p] <= io_ff[IO_DATA_LSB + p]; // R11
      end
      if (ctrl_ff[CTRL_STB_IND]) begin
        gp_pin_oe_n[NUM_GPO-1] <= 1'b0; // R12 R18
        gp_pin_out[NUM_GPO-1] <= ctrl_ff[CTRL_STANDBY]; // R12 R18
      end
    end
  end

  // ==========================================================================
  // Clock pin and interrupt routing
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_pin_irq_sel <= 1'b0;
      clk_pin_clock_out_en <= 1'b0;
      clk_pin_irq_out <= 1'b0;
      sync_clear_bit <= 1'b0;
    end else begin
      clk_pin_irq_sel <= io_ff[IO_INTSEL_LSB +: 2] == INT_SEL_CLK_PIN; // R19
      clk_pin_clock_out_en <= ctrl_ff[CTRL_CLK_USED] &&
                              io_ff[IO_INTSEL_LSB +: 2] != INT_SEL_CLK_PIN; // R19
      clk_pin_irq_out <= irq_event && io_ff[IO_INTSEL_LSB +: 2] == INT_SEL_CLK_PIN; // R19
      sync_clear_bit <= io_ff[IO_SYNCCLR_BIT];
    end
  end

endmodule : fcg_top

//--- testbench/fcg_top_assertions.sv
// Port-level checker for the front-end configuration block
`timescale 1ns/10ps
module fcg_top_checker
  import fcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic conv_done,
  input wire logic irq_event,
  input wire logic [2:0] gain_stage_select,
  input wire logic gain_stage_skip,
  input wire logic [NUM_AIN-1:0] bias_pin_enable,
  input wire logic [3:0] active_channel,
  input wire logic [NUM_GPO-1:0] gp_pin_out,
  input wire logic [NUM_GPO-1:0] gp_pin_oe_n,
  input wire logic clk_pin_clock_out_en,
  input wire logic clk_pin_irq_sel,
  input wire logic clk_pin_irq_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr_go;
  // Both halves taken together, as the bench always offers them
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ==========================================================================
  // Properties
  // ==========================================================================
  a_skip_unity: assert property (gain_stage_skip |-> gain_stage_select == 3'h0)
    else $error("gain code not unity while skipped");
  a_irq_override: assert property (clk_pin_irq_sel |-> !clk_pin_clock_out_en)
    else $error("clock out still enabled with irq on clock pin");
  a_irq_follow: assert property (clk_pin_irq_sel && $past(clk_pin_irq_sel)
    |-> clk_pin_irq_out == $past(irq_event)) else $error("irq pin does not follow event");
  a_chan_boundary: assert property ($changed(active_channel) |-> $past(conv_done, 2))
    else $error("channel changed away from a conversion boundary");
  a_gpo_follow: assert property (wr_go && s_axi_awaddr == 8'h0c |-> ##3
    gp_pin_oe_n[1:0] == ~$past(s_axi_wdata[2:1], 3) &&
    gp_pin_out[1:0] == $past(s_axi_wdata[6:5], 3)) else $error("gp outputs wrong");
  a_bias_write: assert property (wr_go && s_axi_awaddr == 8'h04 |-> ##3
    bias_pin_enable == $past(s_axi_wdata[7:0], 3)) else $error("bias pins wrong");
  a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_accept_closed: assert property (wr_go |=> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted while one in flight");
endmodule : fcg_top_checker

bind fcg_top fcg_top_checker u_chk (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .conv_done,
  .irq_event, .gain_stage_select, .gain_stage_skip, .bias_pin_enable, .active_channel,
  .gp_pin_out, .gp_pin_oe_n, .clk_pin_clock_out_en, .clk_pin_irq_sel, .clk_pin_irq_out);

//--- testbench/frontend_config_and_gpo_bench.sv
// Register-level bench for the front-end configuration block
`timescale 1ns/10ps
module frontend_config_and_gpo_bench;
  import fcg_pkg::*;
  logic ref_clk, nrst, conv_done, irq_event;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, active_channel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] positive_input_select, negative_input_select;
  logic [4:0] excitation_a_pin_route, excitation_b_pin_route;
  logic [2:0] gain_stage_select, excitation_a_magnitude, excitation_b_magnitude;
  logic [NUM_AIN-1:0] bias_pin_enable;
  logic [NUM_GPO-1:0] gp_pin_out, gp_pin_oe_n;
  logic gain_stage_skip, bridge_low_side_switch, second_ref_enable, standby_active;
  logic clk_pin_clock_out_en, clk_pin_irq_sel, clk_pin_irq_out, sync_clear_bit;
  int bad_count, n_checks;

  fcg_top dut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", e, s_axi_rdata);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge ref_clk);
  endtask : settle

  task automatic pulse();
    @(posedge ref_clk);
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    settle();
  endtask : pulse

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    {nrst, conv_done, irq_event, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    settle();
    chk("oe_n", 32'h7, 32'(gp_pin_oe_n));
    chk("neg", 32'h1, 32'(negative_input_select));
    rd(8'h0c, 32'h0, RESP_OKAY);
    wr(8'h00, 32'h0, RESP_OKAY);
    wr(8'h0c, 32'hffffffff, RESP_OKAY);
    rd(8'h0c, 32'h07ee, RESP_OKAY);
    chk("oe_n", 32'h0, 32'(gp_pin_oe_n));
    chk("out", 32'h7, 32'(gp_pin_out));
    chk("sync", 32'h1, 32'(sync_clear_bit));
    wr(8'h0c, 32'ha2, RESP_OKAY);
    wr(8'h04, 32'ha5, RESP_OKAY);
    wr(8'h10, 32'h1, RESP_OKAY);
    wr(8'h40, 32'h2140cf, RESP_OKAY);
    wr(8'h80, 32'h2b7, RESP_OKAY);
    settle();
    chk("oe_n", 32'h6, 32'(gp_pin_oe_n));
    chk("out", 32'h5, 32'(gp_pin_out));
    chk("bias", 32'ha5, 32'(bias_pin_enable));
    chk("ref2", 32'h1, 32'(second_ref_enable));
    chk("pos", 32'h7, 32'(positive_input_select));
    chk("neg", 32'h3, 32'(negative_input_select));
    chk("bridge", 32'h1, 32'(bridge_low_side_switch));
    chk("routes", 32'h42, {excitation_a_pin_route, excitation_b_pin_route});
    chk("gain", 32'h7, 32'(gain_stage_select));
    chk("mags", 32'h1d, {excitation_a_magnitude, excitation_b_magnitude});
    wr(8'h80, 32'h2bf, RESP_OKAY);
    settle();
    chk("skip", 32'h8, {gain_stage_skip, gain_stage_select});
    wr(8'h00, 32'h19, RESP_OKAY);
    settle();
    chk("mags", 32'h0, {excitation_a_magnitude, excitation_b_magnitude});
    chk("stby", 32'h1, 32'(standby_active));
    chk("oe_n", 32'h2, 32'(gp_pin_oe_n));
    chk("out", 32'h5, 32'(gp_pin_out));
    wr(8'h00, 32'h20, RESP_OKAY);
    settle();
    chk("clkout", 32'h1, 32'(clk_pin_clock_out_en));
    irq_event <= 1'b1;
    wr(8'h0c, 32'h100, RESP_OKAY);
    settle();
    chk("irq", 32'h3, {clk_pin_clock_out_en, clk_pin_irq_sel, clk_pin_irq_out});
    wr(8'h3c, 32'h1, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    wr(8'h7c, 32'h398b, RESP_OKAY);
    wr(8'h9c, 32'h4, RESP_OKAY);
    wr(8'h00, 32'h2, RESP_OKAY);
    settle();
    chk("chan", 32'h0, 32'(active_channel));
    pulse();
    chk("chan", 32'hf, 32'(active_channel));
    chk("sel", 32'hc5, {negative_input_select, positive_input_select});
    chk("gain", 32'h4, {bridge_low_side_switch, gain_stage_select});
    pulse();
    chk("chan", 32'h0, 32'(active_channel));
    chk("bridge", 32'h1, 32'(bridge_low_side_switch));
    rd(8'h08, 32'h300, RESP_OKAY);
    wr(8'h00, 32'h4, RESP_OKAY);
    rd(8'h04, 32'h0, RESP_OKAY);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule : frontend_config_and_gpo_bench
